// *** core/cmb_core_end.sv ***
`timescale 1ns/1ps
// What this block does
// (R01) Lock held high during swap operations
// (R02) State flag low 32-bit, high compressed
// (R03) All write data leaves on write bus
// (R04) Memory captures write bus at cycle end
// (R05) Read bus sampled at bus cycle end
// (R06) Coprocessor transfers use read bus
// (R07) Abort sampled only in N/S cycles
// (R08) Data abort raises data abort event
// (R09) Fetch abort marked, raised when executed
// (R10) Memory ignores low address bits by size
// (R11) Core extracts narrow reads from word
// (R12) Halfword lane by addr bit 1, endian
// (R13) Byte lane by addr low bits, endian
// (R14) Narrow writes replicated over all lanes
// (R15) Memory supports single byte writes
// (R16) Cycle completes only when enable high
// (R17) Address one bus cycle ahead of data
// (R18) Next address may show before completion
// (R19) Controller latches request when enable high
// (R20) Clock stop needs enable and gate low
// (R21) Size codes 00, 01, 10 only
// (R22) Write high for writes, low reads
// (R23) Everything on rising clock edge
// (R24) Outputs stable while cycle stretched
module cmb_core_end
    import cmb_pkg::*;
(
    // Bus side
    cmb_if.core bus,
    // Request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [1:0] req_prot,
    input wire logic req_seq,
    input wire logic req_coproc,
    input wire logic req_fetch,
    input wire logic req_swap,
    input wire logic [31:0] req_wdata,
    input wire logic compressed_mode,
    // Answer port
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic resp_data_abort,
    output logic resp_fetch_abort,
    // Execution report
    input wire logic exec_valid,
    input wire logic exec_tag,
    output logic prefetch_abort
);

    // ************************************************************
    // Pipeline registers
    // ************************************************************
    logic done;
    logic d_active;
    logic d_mem;
    logic d_write;
    logic d_fetch;
    logic [1:0] d_size;
    logic [1:0] d_addr_lo;
    logic [31:0] d_wdata;
    logic [31:0] lane;
    logic [31:0] next_wdata;
    logic [1:0] fetch_abort_mark;
    logic a_fetch;
    logic [31:0] a_wdata;

    assign done = bus.cycle_stretch_enable; // R16 R23
    // New request is only taken at a completing edge
    assign req_ready = done; // R17 R18

    // ************************************************************
    // Address phase: held while stretched
    // ************************************************************
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            bus.addr <= ADDR_RESET;
            bus.write <= 1'b0;
            bus.size <= SIZE_WORD;
            bus.prot <= PROT_RESET;
            bus.lock <= 1'b0;
            bus.cycle_kind <= KIND_I;
        end else if (done) begin // R24
            if (req_valid) begin
                bus.addr <= req_addr; // R17
                bus.write <= req_write; // R22
                // Reserved code is never issued
                bus.size <= (req_size == 2'h3) ? SIZE_WORD : req_size; // R21
                bus.prot <= req_prot;
                bus.lock <= req_swap; // R01
                bus.cycle_kind <= req_coproc ? KIND_C : (req_seq ? KIND_S : KIND_N);
            end else begin
                bus.cycle_kind <= KIND_I;
                bus.lock <= 1'b0;
            end
        end
    end

    // State flag tracks execution state
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            bus.instr_state_flag <= 1'b0;
        end else if (done) begin
            bus.instr_state_flag <= compressed_mode; // R02
        end
    end

    // Replicate narrow data across lanes
    always_comb begin
        case (req_size)
            SIZE_BYTE: next_wdata = {4{req_wdata[7:0]}}; // R14
            SIZE_HALF: next_wdata = {2{req_wdata[15:0]}}; // R14
            default: next_wdata = req_wdata;
        endcase
    end

    // Side info of the pending address phase; the bus does not carry it
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            a_fetch <= 1'b0;
            a_wdata <= DATA_RESET;
        end else if (done && req_valid) begin // R24
            a_fetch <= req_fetch;
            a_wdata <= next_wdata; // R14
        end
    end

    // ************************************************************
    // Data phase: one bus cycle behind the address phase
    // ************************************************************
    // Loaded from the outgoing address phase at each completing edge, so lane
    // choice and abort kind always match the word the memory returns
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            d_active <= 1'b0;
            d_mem <= 1'b0;
            d_write <= 1'b0;
            d_fetch <= 1'b0;
            d_size <= SIZE_WORD;
            d_addr_lo <= 2'h0;
            d_wdata <= DATA_RESET;
        end else if (done) begin // R17 R24
            d_active <= (bus.cycle_kind != KIND_I);
            d_mem <= (bus.cycle_kind == KIND_N) || (bus.cycle_kind == KIND_S); // R07
            d_write <= bus.write;
            d_fetch <= a_fetch;
            d_size <= bus.size;
            d_addr_lo <= bus.addr[1:0];
            d_wdata <= a_wdata; // R03
        end
    end

    // Write bus carries data only in its data phase
    assign bus.wdata = d_wdata; // R03 R04

    // ************************************************************
    // Lane extraction for narrow reads
    // ************************************************************
    always_comb begin
        lane = bus.rdata; // R05 R06
        if (d_size == SIZE_HALF) begin
            if (d_addr_lo[1] ^ bus.endian_select) begin // R12
                lane = {16'h0000, bus.rdata[31:16]};
            end else begin
                lane = {16'h0000, bus.rdata[15:0]};
            end
        end else if (d_size == SIZE_BYTE) begin
            case (d_addr_lo ^ {2{bus.endian_select}}) // R13
                2'h0: lane = {24'h000000, bus.rdata[7:0]};
                2'h1: lane = {24'h000000, bus.rdata[15:8]};
                2'h2: lane = {24'h000000, bus.rdata[23:16]};
                default: lane = {24'h000000, bus.rdata[31:24]};
            endcase
        end
    end

    // Answer captured at completing edge
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            resp_valid <= 1'b0;
            resp_data <= DATA_RESET;
            resp_data_abort <= 1'b0;
            resp_fetch_abort <= 1'b0;
        end else begin
            resp_valid <= done && d_active;
            if (done && d_active) begin
                resp_data <= d_write ? DATA_RESET : lane; // R05 R11
                resp_data_abort <= d_mem && !d_fetch && bus.abort; // R07 R08
                resp_fetch_abort <= d_mem && d_fetch && bus.abort; // R07 R09
            end
        end
    end

    // Abort marks follow fetched opcode; raised only on execution
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            fetch_abort_mark <= 2'h0;
            prefetch_abort <= 1'b0;
        end else begin
            prefetch_abort <= exec_valid && fetch_abort_mark[exec_tag]; // R09
            if (done && d_active && d_mem && d_fetch) begin
                fetch_abort_mark <= {fetch_abort_mark[0], bus.abort}; // R09
            end
        end
    end

endmodule : cmb_core_end

// *** core/cmb_pkg.sv ***
package cmb_pkg;

    // ************************************************************
    // Transfer size codes
    // ************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // ************************************************************
    // Cycle kind codes
    // ************************************************************
    localparam logic [1:0] KIND_I = 2'h0;
    localparam logic [1:0] KIND_C = 2'h1;
    localparam logic [1:0] KIND_N = 2'h2;
    localparam logic [1:0] KIND_S = 2'h3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [1:0] PROT_RESET = 2'h0;

    // One-hot state codes, not used by either end
    typedef enum logic [3:0] {
        CMB_IDLE = 4'h1,
        CMB_ISSUE = 4'h2,
        CMB_DATA = 4'h4,
        CMB_HOLD = 4'h8
    } cmb_state_type;

endpackage : cmb_pkg

// *** core/cmb_if.sv ***
`timescale 1ns/1ps
interface cmb_if (
    input wire logic core_clk,
    input wire logic reset_n
);
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [1:0] prot;
    logic lock;
    logic [1:0] cycle_kind;
    logic instr_state_flag;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic abort;
    logic cycle_stretch_enable;
    logic endian_select;
    logic debug_clock_gate;

    modport core (
        input core_clk, reset_n, rdata, abort, cycle_stretch_enable, endian_select,
        output addr, write, size, prot, lock, cycle_kind, instr_state_flag, wdata
    );
    modport mem (
        input core_clk, reset_n, addr, write, size, prot, lock, cycle_kind,
        input instr_state_flag, wdata,
        output rdata, abort, cycle_stretch_enable, endian_select, debug_clock_gate
    );
endinterface : cmb_if

// *** core/cmb_mem_end.sv ***
`timescale 1ns/1ps
module cmb_mem_end
    import cmb_pkg::*;
#(
    parameter int DEPTH_WORDS = 256,
    parameter int WAIT_CLOCKS = 1
)
(
    // Bus side
    cmb_if.mem bus,
    // Configuration
    input wire logic big_endian,
    input wire logic sleep_req,
    input wire logic [31:0] abort_base,
    // Coprocessor data in
    input wire logic [31:0] coproc_rdata,
    // Captured coprocessor write data
    output logic [31:0] coproc_wdata,
    output logic coproc_wvalid
);

    localparam int AW = $clog2(DEPTH_WORDS);

    // Refuse sizes that the index and the wait counter cannot serve
    if (DEPTH_WORDS < 2 || (1 << AW) != DEPTH_WORDS || WAIT_CLOCKS < 1 || WAIT_CLOCKS > 15)
    begin : g_bad_params
        $error("cmb_mem_end: unsupported parameters");
    end

    // ************************************************************
    // Storage and latched request
    // ************************************************************
    logic [31:0] rd_word;
    logic [31:0] a_addr;
    logic a_write;
    logic [1:0] a_size;
    logic [1:0] a_kind;
    logic [3:0] wait_cnt;
    logic [3:0] be;
    logic [AW-1:0] widx;
    logic active;

    assign widx = a_addr[AW+1:2]; // R10
    assign active = (a_kind == KIND_N) || (a_kind == KIND_S);
    assign bus.endian_select = big_endian;
    // Clock stop needs both low; gate is the inverse of sleep_req
    assign bus.debug_clock_gate = !sleep_req; // R20

    // Stretch each active cycle by WAIT_CLOCKS-1 clocks
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            wait_cnt <= 4'h0;
        end else if (bus.cycle_stretch_enable) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    assign bus.cycle_stretch_enable = !sleep_req &&
        (!active || (wait_cnt >= 4'(WAIT_CLOCKS - 1))); // R16

    // Latch request only on completing edges
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            a_addr <= ADDR_RESET;
            a_write <= 1'b0;
            a_size <= SIZE_WORD;
            a_kind <= KIND_I;
        end else if (bus.cycle_stretch_enable) begin // R19
            a_addr <= bus.addr;
            a_write <= bus.write;
            a_size <= bus.size;
            a_kind <= bus.cycle_kind;
        end
    end

    // Byte enables by size and endian
    always_comb begin
        case (a_size)
            SIZE_BYTE: be = 4'h1 << (a_addr[1:0] ^ {2{big_endian}});
            SIZE_HALF: be = (a_addr[1] ^ big_endian) ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
    end

    // Per-byte write at end of write cycle; one array per lane keeps one writer each
    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            logic [7:0] lane_mem [DEPTH_WORDS];
            always_ff @(posedge bus.core_clk) begin
                if (bus.cycle_stretch_enable && active && a_write && be[b]) begin // R04 R15
                    lane_mem[widx] <= bus.wdata[8*b +: 8];
                end
            end
            assign rd_word[8*b +: 8] = lane_mem[widx];
        end
    endgenerate

    // Full word returned; coprocessor data in C cycles
    assign bus.rdata = (a_kind == KIND_C) ? coproc_rdata : rd_word; // R06 R11
    assign bus.abort = active && (a_addr >= abort_base);

    // Coprocessor write capture
    always_ff @(posedge bus.core_clk or negedge bus.reset_n) begin
        if (!bus.reset_n) begin
            coproc_wdata <= DATA_RESET;
            coproc_wvalid <= 1'b0;
        end else begin
            coproc_wvalid <= bus.cycle_stretch_enable && (a_kind == KIND_C) && a_write;
            if (bus.cycle_stretch_enable && (a_kind == KIND_C) && a_write) begin
                coproc_wdata <= bus.wdata; // R03
            end
        end
    end

endmodule : cmb_mem_end

// *** tb/cmb_checker.sv ***
`timescale 1ns/1ps
module cmb_checker
    import cmb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Core outputs
    input wire logic [31:0] addr,
    input wire logic write,
    input wire logic [1:0] size,
    input wire logic lock,
    input wire logic [1:0] cycle_kind,
    input wire logic [31:0] wdata,
    // Memory output
    input wire logic cycle_stretch_enable
);
    logic en;
    logic act;

    // Short names; act marks memory cycles
    assign en = cycle_stretch_enable;
    assign act = (cycle_kind == KIND_N) || (cycle_kind == KIND_S);

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ********
    // Assertions
    // ********
    chk_size_legal: assert property (size != 2'h3)
        else $error("reserved size code on bus");
    chk_class_hold: assert property (!en |=> $stable({addr, write, size, lock, cycle_kind}))
        else $error("address class moved in stretched cycle");
    chk_data_hold: assert property (!en |=> $stable(wdata))
        else $error("write data moved in stretched cycle");
    // Two extra clocks: the bench runs the memory end with three clocks per phase
    chk_stretch_len: assert property (en && act |=> !en [*2] ##1 en)
        else $error("memory data phase has wrong length");
    chk_plain_fast: assert property (en && !act |=> en)
        else $error("idle or coprocessor cycle stretched");
    chk_byte_copy: assert property (en && write && act && size == SIZE_BYTE |=>
        wdata == {4{wdata[7:0]}})
        else $error("byte write not replicated");
    chk_half_copy: assert property (en && write && act && size == SIZE_HALF |=>
        wdata == {2{wdata[15:0]}})
        else $error("halfword write not replicated");
    chk_lock_start: assert property ($rose(lock) |-> cycle_kind == KIND_N && !write)
        else $error("lock did not start on the swap read");

    // Main scenarios reached
    cover property (en && act && write && size == SIZE_BYTE);
    cover property (lock);
    cover property (cycle_kind == KIND_C);
    cover property (!en && act);
endmodule : cmb_checker

// *** tb/tb_cpu_memory_bus_interface.sv ***
`timescale 1ns/1ps
module tb_cpu_memory_bus_interface
    import cmb_pkg::*;
    ;
    logic core_clk;
    logic reset_n;
    logic req_valid, req_write, req_seq, req_coproc, req_fetch, req_swap;
    logic compressed_mode, exec_valid, exec_tag, big_endian, sleep_req;
    logic [31:0] req_addr, req_wdata, abort_base, coproc_rdata;
    logic [1:0] req_size, req_prot;
    logic req_ready, resp_valid, resp_data_abort, resp_fetch_abort, prefetch_abort;
    logic [31:0] resp_data, coproc_wdata, r_data, cw;
    logic coproc_wvalid, r_dab, r_fab, saw_lock;
    int mismatches = 0;
    int n_compared = 0;

    // ********
    // Both ends on one interface
    // ********
    cmb_if cmb_if_i (.core_clk, .reset_n);
    cmb_core_end cmb_core_end_i (.bus(cmb_if_i), .req_valid, .req_ready, .req_addr,
        .req_write, .req_size, .req_prot, .req_seq, .req_coproc, .req_fetch, .req_swap,
        .req_wdata, .compressed_mode, .resp_valid, .resp_data, .resp_data_abort,
        .resp_fetch_abort, .exec_valid, .exec_tag, .prefetch_abort);
    // Three clocks per memory phase, so every N and S access is stretched
    cmb_mem_end #(.DEPTH_WORDS(256), .WAIT_CLOCKS(3)) cmb_mem_end_i (.bus(cmb_if_i),
        .big_endian, .sleep_req, .abort_base, .coproc_rdata, .coproc_wdata, .coproc_wvalid);
    cmb_checker cmb_checker_i (.core_clk, .reset_n, .addr(cmb_if_i.addr),
        .write(cmb_if_i.write), .size(cmb_if_i.size), .lock(cmb_if_i.lock),
        .cycle_kind(cmb_if_i.cycle_kind), .wdata(cmb_if_i.wdata),
        .cycle_stretch_enable(cmb_if_i.cycle_stretch_enable));

    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Catch one-cycle pulses and levels between checks
    always @(negedge core_clk) begin
        if (coproc_wvalid === 1'b1) cw = coproc_wdata;
        if (cmb_if_i.lock === 1'b1) saw_lock = 1'b1;
    end

    // ********
    // Tasks
    // ********
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    // Bounded wait on ready (0) or response (1); a hang ends the run
    task automatic wait_hi(input bit w);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((w ? resp_valid : req_ready) !== 1'b1 && n < 50);
        if ((w ? resp_valid : req_ready) !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask : wait_hi

    // One request held until taken, then its answer; fl is {coproc, fetch, swap}
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz,
            input logic [31:0] wd, input logic [2:0] fl);
        @(posedge core_clk);
        req_addr <= a;
        req_write <= w;
        req_size <= sz;
        req_wdata <= wd;
        {req_coproc, req_fetch, req_swap} <= fl;
        req_valid <= 1'b1;
        wait_hi(1'b0);
        @(posedge core_clk);
        req_valid <= 1'b0;
        wait_hi(1'b1);
        r_data = resp_data;
        r_dab = resp_data_abort;
        r_fab = resp_fetch_abort;
    endtask : acc

    // Report the latest fetch as executed
    task automatic exe(input logic exp);
        @(posedge core_clk);
        exec_valid <= 1'b1;
        @(posedge core_clk);
        exec_valid <= 1'b0;
        @(negedge core_clk);
        chk(prefetch_abort, exp);
    endtask : exe

    // ********
    // Stimulus
    // ********
    initial begin
        reset_n = 1'b0;
        {req_valid, req_write, req_seq, req_coproc, req_fetch, req_swap} = 6'h00;
        {compressed_mode, exec_valid, exec_tag, big_endian, sleep_req} = 5'h00;
        {req_addr, req_wdata, req_size, req_prot} = {64'h0, 2'h2, 2'h1};
        abort_base = 32'h80000000;
        coproc_rdata = 32'h5a5ac3c3;
        {cw, saw_lock} = 33'h0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        acc(32'h10, 1'b1, SIZE_WORD, 32'h11223344, 3'h0);
        acc(32'h10, 1'b0, SIZE_WORD, 32'h0, 3'h0);
        chk(r_data, 32'h11223344);
        // Narrow reads in both byte orders
        for (int e = 0; e < 2; e++) begin
            @(posedge core_clk);
            big_endian <= e[0];
            for (int i = 0; i < 4; i++) begin
                acc(32'h10 + i, 1'b0, SIZE_BYTE, 32'h0, 3'h0);
                chk(r_data, (32'h11223344 >> (8 * (e ? 3 - i : i))) & 32'hff);
                if (!i[0]) begin
                    acc(32'h10 + i, 1'b0, SIZE_HALF, 32'h0, 3'h0);
                    chk(r_data, (32'h11223344 >> (8 * (e ? 2 - i : i))) & 32'hffff);
                end
            end
        end
        @(posedge core_clk);
        big_endian <= 1'b0;
        acc(32'h13, 1'b1, SIZE_BYTE, 32'hab, 3'h0);
        acc(32'h10, 1'b1, SIZE_HALF, 32'hbeef, 3'h0);
        acc(32'h10, 1'b0, SIZE_WORD, 32'h0, 3'h0);
        chk(r_data, 32'hab22beef);
        // Swap read and write back to back, so lock never drops between them
        @(posedge core_clk);
        req_addr <= 32'h14;
        req_write <= 1'b0;
        req_size <= SIZE_WORD;
        req_wdata <= 32'h5;
        {req_coproc, req_fetch, req_swap} <= 3'h1;
        req_valid <= 1'b1;
        wait_hi(1'b0);
        @(posedge core_clk);
        req_write <= 1'b1;
        wait_hi(1'b0);
        @(posedge core_clk);
        req_valid <= 1'b0;
        wait_hi(1'b1);
        wait_hi(1'b1);
        chk(saw_lock, 32'h1);
        acc(32'h14, 1'b0, SIZE_WORD, 32'h0, 3'h0);
        chk(r_data, 32'h5);
        acc(32'h80000000, 1'b0, SIZE_WORD, 32'h0, 3'h0);
        chk(r_dab, 32'h1);
        acc(32'h80000010, 1'b0, SIZE_WORD, 32'h0, 3'h2);
        chk({r_dab, r_fab}, 32'h1);
        exe(1'b1);
        acc(32'h20, 1'b0, SIZE_WORD, 32'h0, 3'h2);
        exe(1'b0);
        acc(32'h0, 1'b1, SIZE_WORD, 32'hc0de1234, 3'h4);
        repeat (2) @(negedge core_clk);
        chk(cw, 32'hc0de1234);
        acc(32'h80000000, 1'b0, SIZE_WORD, 32'h0, 3'h4);
        chk(r_data, 32'h5a5ac3c3);
        chk(r_dab, 32'h0);
        for (int m = 1; m >= 0; m--) begin
            @(posedge core_clk);
            compressed_mode <= m[0];
            acc(32'h10, 1'b0, SIZE_WORD, 32'h0, 3'h0);
            chk(cmb_if_i.instr_state_flag, m);
        end
        @(posedge core_clk);
        sleep_req <= 1'b1;
        @(negedge core_clk);
        chk(cmb_if_i.debug_clock_gate, 32'h0);
        chk(cmb_if_i.cycle_stretch_enable, 32'h0);
        end_sim();
    end
endmodule : tb_cpu_memory_bus_interface
